// File: rtl/l2cb_bus_pin_logic.v
// processor bus side pin logic of a look-aside secondary cache
// What this block does
// - take address in; drive snoop address out
// - busy qualifies grants; driven during own tenure
// - parity error low one cycle after start
// - parity checking only while strap is low
// - retry asserted on snoop hitting dirty line
// - four processor grants combined by logical or
// - primary processor bus request is monitored
`timescale 1ns/1ps
`include "l2cb_consts.vh"

module l2cb_bus_pin_logic #(
  parameter ADDR_W     = `L2CB_ADDR_WIDTH,   // address lines
  parameter PAR_W      = `L2CB_PAR_WIDTH,    // parity bits, one per byte
  parameter TENURE_CYC = `L2CB_TENURE_CYCLES // own tenure length in cycles
) (
  // clock and reset (clock is the processor clock itself)
  input  wire              core_clk,
  input  wire              rst,
  // address lines, bit ADDR_W-1 is the most significant line
  input  wire [ADDR_W-1:0] addressLinesIn,
  output reg  [ADDR_W-1:0] addressLinesOut,
  output reg               addressLinesOe,
  // address parity bits, bit PAR_W-1 covers the top byte
  input  wire [PAR_W-1:0]  addressParityBitsIn,
  // parity error output, open drain style
  output reg               addressParityErrorOut_n,
  output reg               addressParityErrorOe,
  input  wire              parityEnableStrap_n,
  // transfer start from the bus
  input  wire              transferStart_n,
  // address bus busy, two way
  input  wire              addressBusBusyIn_n,
  output reg               addressBusBusyOut_n,
  output reg               addressBusBusyOe,
  // address retry, two way
  input  wire              addressRetryIn_n,
  output reg               addressRetryOut_n,
  output reg               addressRetryOe,
  // processor grants and request
  input  wire              primaryProcessorGrant_n,
  input  wire              secondProcessorGrant_n,
  input  wire              thirdProcessorGrant_n,
  input  wire              fourthProcessorGrant_n,
  input  wire              processorBusRequest_n,
  // core side: snoop address presentation
  input  wire              snoopReq,
  input  wire [ADDR_W-1:0] snoopAddr,
  output reg               snoopBusy,
  output reg               snoopDone,
  // core side: retry request after a dirty snoop hit
  input  wire              dirtySnoopHit,
  // core side: observed bus state
  output reg               anyGrant,
  output reg               grantQualified,
  output reg               busRequestSeen,
  output reg               retrySeen,
  output reg               addrCaptured,
  output reg  [ADDR_W-1:0] capturedAddr,
  output reg               parityErrPulse
);

  // one-hot tenure states
  localparam [2:0] ST_IDLE   = 3'h1;     // nothing pending
  localparam [2:0] ST_WAIT   = 3'h2;     // request held, waiting for grant
  localparam [2:0] ST_TENURE = 3'h4;     // driving busy and address

  localparam BYTE_W = `L2CB_BYTE_WIDTH;
  localparam CNT_W  = `L2CB_TENURE_CNT_W;
  localparam integer     TENURE_LAST_I = TENURE_CYC - 1;               // last tenure count, full width
  // only the low counter bits are kept; the counter is sized to hold the tenure
  localparam [CNT_W-1:0] TENURE_LAST   = TENURE_LAST_I[CNT_W-1:0];

  reg  [2:0]        state_r;             // tenure state
  reg  [2:0]        state_nxt;
  reg  [CNT_W-1:0]  tenureCnt_r;         // cycles spent in tenure
  reg  [CNT_W-1:0]  tenureCnt_nxt;
  reg  [ADDR_W-1:0] snoopAddr_r;         // address held for the tenure
  reg  [1:0]        retryPhase_r;        // bit1 assert low, bit0 drive high
  wire [PAR_W-1:0]  byteErr;             // per byte parity error
  wire              grantLow;            // any processor grant asserted
  wire              busFree;             // nobody holds the address bus
  wire              tsSeen;              // transfer start sampled
  wire              parityOn;            // strap enables checking
  wire              parityFault;         // error on a started transfer

  // any of four grants counts, so up to four processors share the cache
  assign grantLow = ~(primaryProcessorGrant_n & secondProcessorGrant_n &
                      thirdProcessorGrant_n & fourthProcessorGrant_n);

  // a grant is only usable while the address bus is not busy
  assign busFree  = addressBusBusyIn_n;

  assign tsSeen   = ~transferStart_n;
  assign parityOn = ~parityEnableStrap_n;

  // one checker per address byte
  genvar gi;
  generate
    for (gi = 0; gi < PAR_W; gi = gi + 1) begin : gParity
      l2cb_odd_parity #(
        .BYTE_W (BYTE_W)
      ) uParity (
        .byteIn (addressLinesIn[gi*BYTE_W +: BYTE_W]),
        .parIn  (addressParityBitsIn[gi]),
        .parErr (byteErr[gi])
      );
    end
  endgenerate

  // a fault only counts while the strap is low and a transfer starts
  assign parityFault = parityOn & tsSeen & (|byteErr);

  // next state for our own address tenure
  always @* begin
    state_nxt     = state_r;
    tenureCnt_nxt = tenureCnt_r;
    case (state_r)
      ST_IDLE: begin
        tenureCnt_nxt = {CNT_W{1'b0}};
        if (snoopReq) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // grant qualified by a free bus before we take it
        if (grantLow && busFree) begin
          state_nxt = ST_TENURE;
        end
      end
      ST_TENURE: begin
        if (tenureCnt_r == TENURE_LAST) begin
          state_nxt     = ST_IDLE;
          tenureCnt_nxt = {CNT_W{1'b0}};
        end else begin
          tenureCnt_nxt = tenureCnt_r + 1'b1;
        end
      end
      default: begin
        // illegal code: fall back to idle rather than lock up
        state_nxt     = ST_IDLE;
        tenureCnt_nxt = {CNT_W{1'b0}};
      end
    endcase
  end

  // tenure state, counter and held address
  always @(posedge core_clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      tenureCnt_r  <= {CNT_W{1'b0}};
      snoopAddr_r  <= {ADDR_W{1'b0}};
    end else begin
      state_r     <= state_nxt;
      tenureCnt_r <= tenureCnt_nxt;
      // address is latched at request so the core may change it after
      if (state_r == ST_IDLE && snoopReq) begin
        snoopAddr_r <= snoopAddr;
      end
    end
  end

  // pins driven during our own tenure; outputs come from flops
  always @(posedge core_clk) begin
    if (rst) begin
      addressLinesOut     <= {ADDR_W{1'b0}};
      addressLinesOe      <= 1'b0;
      addressBusBusyOut_n <= 1'b1;
      addressBusBusyOe    <= 1'b0;
      snoopBusy           <= 1'b0;
      snoopDone           <= 1'b0;
    end else begin
      // busy is held low for the whole tenure, the lines carry the address
      addressBusBusyOe    <= (state_nxt == ST_TENURE);
      addressBusBusyOut_n <= ~(state_nxt == ST_TENURE);
      addressLinesOe      <= (state_nxt == ST_TENURE);
      if (state_r == ST_IDLE && snoopReq) begin
        addressLinesOut <= snoopAddr;
      end else begin
        addressLinesOut <= snoopAddr_r;
      end
      snoopBusy <= (state_nxt != ST_IDLE);
      snoopDone <= (state_r == ST_TENURE) && (state_nxt == ST_IDLE);
    end
  end

  // parity error: low in the cycle after transfer start, then released
  always @(posedge core_clk) begin
    if (rst) begin
      addressParityErrorOut_n <= 1'b1;
      addressParityErrorOe    <= 1'b0;
      parityErrPulse          <= 1'b0;
    end else begin
      // a fresh fault on a back-to-back start re-drives the pin
      addressParityErrorOe    <= parityFault;
      addressParityErrorOut_n <= ~parityFault;
      parityErrPulse          <= parityFault;
    end
  end

  // retry: one cycle low, one cycle driven high so the line recovers fast
  always @(posedge core_clk) begin
    if (rst) begin
      retryPhase_r      <= 2'h0;
      addressRetryOut_n <= 1'b1;
      addressRetryOe    <= 1'b0;
    end else begin
      if (dirtySnoopHit) begin
        retryPhase_r <= 2'h2;
      end else begin
        retryPhase_r <= {1'b0, retryPhase_r[1]};
      end
      // a new hit while negating restarts the assertion
      addressRetryOe    <= dirtySnoopHit | retryPhase_r[1];
      addressRetryOut_n <= ~dirtySnoopHit;
    end
  end

  // observed bus state for the core
  always @(posedge core_clk) begin
    if (rst) begin
      anyGrant       <= 1'b0;
      grantQualified <= 1'b0;
      busRequestSeen <= 1'b0;
      retrySeen      <= 1'b0;
      addrCaptured   <= 1'b0;
      capturedAddr   <= {ADDR_W{1'b0}};
    end else begin
      anyGrant       <= grantLow;
      // our own busy also counts as the bus being held; busy in is not masked by our busy drive
      grantQualified <= grantLow & busFree;
      busRequestSeen <= ~processorBusRequest_n;
      retrySeen      <= ~addressRetryIn_n;
      // capture processor address at transfer start, except our own
      addrCaptured   <= tsSeen & ~addressLinesOe;
      if (tsSeen && !addressLinesOe) begin
        capturedAddr <= addressLinesIn;
      end
    end
  end

endmodule // l2cb_bus_pin_logic

// File: rtl/l2cb_consts.vh
// constants for the secondary cache processor bus pin logic
`ifndef L2CB_CONSTS_VH
`define L2CB_CONSTS_VH

// clock figures
`define L2CB_CLK_PERIOD_NS      40
`define L2CB_CLK_MHZ            25

// address bus shape
`define L2CB_ADDR_WIDTH         32
`define L2CB_PAR_WIDTH          4
`define L2CB_BYTE_WIDTH         8

// hard reset hold figure, in clock cycles, kept by the system
`define L2CB_HARD_RESET_IN_MIN_CYCLES  16

// parity error pulse: driven low for this many cycles, then released
`define L2CB_APE_DRIVE_CYCLES   1

// own address tenure length in cycles (abb and address driven)
`define L2CB_TENURE_CYCLES      2
`define L2CB_TENURE_CNT_W       4

// retry: asserted cycles, then one cycle of driven negation before release
`define L2CB_RETRY_ASSERT_CYCLES 1

`endif

// File: rtl/l2cb_odd_parity.v
// odd parity checker for one address byte and its parity bit
`timescale 1ns/1ps

module l2cb_odd_parity #(
  parameter BYTE_W = 8                // bits in one checked byte
) (
  // checked byte
  input  wire [BYTE_W-1:0] byteIn,    // address byte
  input  wire              parIn,     // its parity bit
  // result
  output wire              parErr     // high when byte plus parity has even ones
);

  // odd parity: the total count of ones must be odd, otherwise an error
  assign parErr = ~(^{byteIn, parIn});

endmodule // l2cb_odd_parity

// File: verification/l2cb_bus_model.sv
// arbiter and shared bus wires on the processor side
`timescale 1ns/1ps
module l2cb_bus_model (
  // clock shared with the device
  input wire core_clk, rst,
  // device drive of busy and retry
  input wire busyOe, busyOut_n, retryOe, retryOut_n,
  // bench commands: other master busy, grant wanted, which line, how slow
  input wire extBusy, grantReq,
  input wire [1:0] grantSel,
  input wire [3:0] grantDelay,
  // resolved pins
  output reg [3:0] grant_n,
  output wire      busyWire_n,
  output wire      retryWire_n
);
  reg [3:0] waitCnt_r; // grant latency countdown
  // both wires carry pull-ups, so a released wire reads high
  assign busyWire_n = !(extBusy || (busyOe && !busyOut_n));
  assign retryWire_n = !(retryOe && !retryOut_n);
  // grant stays up regardless of busy; the device taking the bus or the bench dropping its request withdraws it
  always @(posedge core_clk) begin
    if (rst || !grantReq || busyOe) begin
      grant_n <= 4'hf;
      waitCnt_r <= grantDelay;
    end else if (waitCnt_r != 4'h0) waitCnt_r <= waitCnt_r - 4'h1;
    else grant_n <= ~(4'h1 << grantSel);
  end
endmodule // l2cb_bus_model

// File: verification/l2cb_bus_sva.sv
// concurrent checks on the processor bus pin logic ports
`timescale 1ns/1ps
module l2cb_bus_sva #(parameter TENURE_CYC = 2) (
  // clock, reset and bus pins
  input wire core_clk, rst, transferStart_n, parityEnableStrap_n, addressBusBusyIn_n, processorBusRequest_n,
  input wire primaryProcessorGrant_n, secondProcessorGrant_n, thirdProcessorGrant_n, fourthProcessorGrant_n,
  input wire [31:0] addressLinesIn,
  input wire [3:0]  addressParityBitsIn,
  // driven pins
  input wire addressLinesOe, addressParityErrorOut_n, addressParityErrorOe, addressBusBusyOut_n, addressBusBusyOe,
  input wire addressRetryOut_n, addressRetryOe,
  // core side
  input wire dirtySnoopHit, anyGrant, grantQualified, busRequestSeen, addrCaptured,
  input wire [31:0] capturedAddr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [31:0] a = addressLinesIn;
  wire [3:0]  p = addressParityBitsIn;
  // some byte plus its bit holds an even count of ones
  wire badPar = ~&{^{a[31:24], p[3]}, ^{a[23:16], p[2]}, ^{a[15:8], p[1]}, ^{a[7:0], p[0]}};
  wire anyG = ~&{primaryProcessorGrant_n, secondProcessorGrant_n, thirdProcessorGrant_n, fourthProcessorGrant_n};
  wire qualW = anyG && addressBusBusyIn_n; // a grant counts only on an idle bus

  par_drive_a: assert property (!transferStart_n && !parityEnableStrap_n && badPar |=> addressParityErrorOe && !addressParityErrorOut_n) else $error("parity error not driven");
  par_cause_a: assert property (addressParityErrorOe |-> $past(badPar) && !$past(transferStart_n)) else $error("parity error without cause");
  par_off_a: assert property (parityEnableStrap_n |=> !addressParityErrorOe) else $error("parity error while disabled");
  par_release_a: assert property (addressParityErrorOe && transferStart_n |=> !addressParityErrorOe) else $error("parity error not released");
  grant_or_a: assert property (!$past(rst) |-> anyGrant == $past(anyG)) else $error("grant combine wrong");
  grant_qual_a: assert property (!$past(rst) |-> grantQualified == $past(qualW)) else $error("grant qualify wrong");
  req_seen_a: assert property (!$past(rst) |-> busRequestSeen != $past(processorBusRequest_n)) else $error("request not seen");
  tenure_hold_a: assert property ($rose(addressBusBusyOe) |-> (!addressBusBusyOut_n && addressLinesOe)[*2] ##1 !addressBusBusyOe) else $error("tenure shape wrong");
  tenure_start_a: assert property ($rose(addressBusBusyOe) |-> $past(qualW)) else $error("tenure without grant");
  retry_drive_a: assert property (dirtySnoopHit |=> addressRetryOe && !addressRetryOut_n) else $error("retry not driven");
  addr_take_a: assert property (!transferStart_n && !addressLinesOe |=> addrCaptured && capturedAddr == $past(a)) else $error("address not taken");
endmodule // l2cb_bus_sva

bind l2cb_bus_pin_logic l2cb_bus_sva #(.TENURE_CYC(TENURE_CYC)) u_sva (.*);

// File: verification/tb_l2cb_bus_pin_logic.sv
// self-checking bench for the processor bus pin logic
`timescale 1ns/1ps
module tb_l2cb_bus_pin_logic;
  logic core_clk, rst, strap_n, ts_n, req_n, sReq, hit, gReq, extBusy;
  logic [31:0] addrDrv, sAddr, aOut, capAddr;
  logic [3:0]  par, grant_n, gDly;
  logic [1:0]  gSel;
  wire         busy_n, retry_n;
  logic aOe, eOut_n, eOe, bOut_n, bOe, rOut_n, rOe, sBusy, sDone, anyG, qualG, reqSeen, rSeen, capd, ePulse;
  int error_cnt = 0, tests_run = 0;
  wire [31:0] aWire = aOe ? aOut : addrDrv; // shared address level

  l2cb_bus_pin_logic u_dut (.core_clk(core_clk), .rst(rst), .addressLinesIn(aWire), .addressLinesOut(aOut),
    .addressLinesOe(aOe), .addressParityBitsIn(par), .addressParityErrorOut_n(eOut_n), .addressParityErrorOe(eOe),
    .parityEnableStrap_n(strap_n), .transferStart_n(ts_n), .addressBusBusyIn_n(busy_n),
    .addressBusBusyOut_n(bOut_n), .addressBusBusyOe(bOe), .addressRetryIn_n(retry_n), .addressRetryOut_n(rOut_n),
    .addressRetryOe(rOe), .primaryProcessorGrant_n(grant_n[0]), .secondProcessorGrant_n(grant_n[1]),
    .thirdProcessorGrant_n(grant_n[2]), .fourthProcessorGrant_n(grant_n[3]), .processorBusRequest_n(req_n),
    .snoopReq(sReq), .snoopAddr(sAddr), .snoopBusy(sBusy), .snoopDone(sDone), .dirtySnoopHit(hit),
    .anyGrant(anyG), .grantQualified(qualG), .busRequestSeen(reqSeen), .retrySeen(rSeen), .addrCaptured(capd),
    .capturedAddr(capAddr), .parityErrPulse(ePulse));
  l2cb_bus_model u_bus (.core_clk(core_clk), .rst(rst), .busyOe(bOe), .busyOut_n(bOut_n), .retryOe(rOe),
    .retryOut_n(rOut_n), .extBusy(extBusy), .grantReq(gReq), .grantSel(gSel), .grantDelay(gDly),
    .grant_n(grant_n), .busyWire_n(busy_n), .retryWire_n(retry_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // inputs move 1 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one start with a chosen byte's parity spoiled (-1 for none)
  task automatic parity_case(input logic [31:0] a, input int bad, input logic s_n);
    logic [3:0] p;
    logic err;
    for (int i = 0; i < 4; i++) p[i] = ~^a[8*i +: 8];
    if (bad >= 0) p[bad] = ~p[bad];
    err = (bad >= 0) && !s_n;
    addrDrv = a; par = p; strap_n = s_n; ts_n = 1'b0;
    tick();
    ts_n = 1'b1;
    check("errOe", eOe, err);
    check("errOut", eOut_n, !err);
    check("errPulse", ePulse, err);
    check("capAddr", capAddr, a);
    tick();
    check("errRelease", eOe, 0);
  endtask
  // grant on one line, then the bus goes busy elsewhere
  task automatic grant_case(input logic [1:0] sel);
    gSel = sel; gDly = 4'h0; gReq = 1'b1; req_n = 1'b0;
    tick(3);
    check("anyGrant", anyG, 1);
    check("qualified", qualG, 1);
    check("reqSeen", reqSeen, 1);
    extBusy = 1'b1;
    tick(2);
    check("busyQual", qualG, 0);
    gReq = 1'b0; extBusy = 1'b0; req_n = 1'b1;
    tick(2);
    check("noGrant", anyG, 0);
    check("reqGone", reqSeen, 0);
  endtask
  // snoop tenure granted while another master still holds the bus
  task automatic snoop_case(input logic [31:0] a, input logic [1:0] sel, input logic [3:0] dly);
    int n;
    n = 0;
    // the model loads its grant latency only in reset, while no grant is wanted or while the device drives busy
    gDly = dly;
    tick();
    extBusy = 1'b1; gSel = sel; gReq = 1'b1; sAddr = a; sReq = 1'b1;
    tick();
    sReq = 1'b0;
    check("snoopBusy", sBusy, 1);
    tick(dly + 3);
    check("heldOff", bOe, 0);
    check("grantSeen", anyG, 1);
    check("heldQual", qualG, 0);
    extBusy = 1'b0;
    while (bOe !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    check("busyDrv", bOut_n, 0);
    check("snoopAddr", aWire, a);
    tick();
    check("busyHeld", {bOe, aOe}, 2'b11);
    tick();
    check("tenureEnd", {bOe, aOe, sDone, sBusy}, 4'b0010);
    gReq = 1'b0;
    tick();
  endtask
  task automatic retry_case;
    hit = 1'b1;
    tick();
    hit = 1'b0;
    check("retryLow", {rOe, rOut_n}, 2'b10);
    tick();
    check("retryHigh", {rOe, rOut_n, rSeen}, 3'b111);
    tick();
    check("retryOff", rOe, 0);
  endtask

  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst = 1'b1; strap_n = 1'b0; ts_n = 1'b1; req_n = 1'b1; sReq = 1'b0; hit = 1'b0; gReq = 1'b0;
    extBusy = 1'b0; addrDrv = 32'h0; sAddr = 32'h0; par = 4'hf; gDly = 4'h0; gSel = 2'h0;
    tick(16);
    rst = 1'b0;
    tick();
    check("resetOe", {aOe, eOe, bOe, rOe}, 4'h0);
    check("resetIdle", {eOut_n, bOut_n, rOut_n, sBusy, sDone}, 5'b11100);
    parity_case(32'h1234_5678, -1, 1'b0);
    for (int i = 0; i < 4; i++) parity_case(32'h80a5_c301 ^ i, i, 1'b0);
    parity_case(32'hdead_beef, 2, 1'b1);
    for (int k = 0; k < 4; k++) grant_case(k[1:0]);
    snoop_case(32'h8000_0001, 2'h0, 4'h0);
    snoop_case(32'h0123_4567, 2'h3, 4'h5);
    retry_case();
    wrap_up();
  end
endmodule // tb_l2cb_bus_pin_logic
